// ===== aol_map.vh
`ifndef AOL_MAP_VH
`define AOL_MAP_VH
// apb byte offsets
`define AOL_A_CTRL 8'h00
`define AOL_A_LO_LIM 8'h04
`define AOL_A_HI_LIM 8'h08
`define AOL_A_FLT_VAL 8'h0C
`define AOL_A_IDL_VAL 8'h10
`define AOL_A_OUT_DATA 8'h14
`define AOL_A_STATUS 8'h18
`define AOL_A_DAC_RB 8'h1C
`define AOL_A_INT_STAT 8'h20
`define AOL_A_INT_MASK 8'h24
// control register fields
`define AOL_C_LO_EN 0
`define AOL_C_HI_EN 1
`define AOL_C_FLT_EN 2
`define AOL_C_IDL_EN 3
`define AOL_C_FMT_LSB 4
`define AOL_C_FMT_MSB 5
`define AOL_C_RET_SW 6
`define AOL_CTRL_W 7
// data formats
`define AOL_FMT_OFFS 2'h0
`define AOL_FMT_SMAG 2'h1
`define AOL_FMT_TWOS 2'h2
`define AOL_FMT_SCAL 2'h3
// reset values
`define AOL_RST_CTRL 7'h00
`define AOL_RST_LO 16'h0000
`define AOL_RST_HI 16'h03E8
`define AOL_RST_VAL 16'h0000
// offset binary midpoint
`define AOL_OB_MID 17'h0_8000
// event / status bit positions
`define AOL_EV_LO 0
`define AOL_EV_HI 1
`define AOL_EV_FLT 2
`define AOL_EV_IDL 3
`define AOL_NEV 4
// divider steps for a 34-bit dividend
`define AOL_DIV_STEPS 6'h22
`endif

// ===== aol_scale.v
`timescale 1ns/100ps
`include "aol_map.vh"
module aol_scale #(
    parameter [15:0] DAC_FS = 16'hFFFF
) (
    input wire i_mclk, // system clock
    input wire i_rst_n, // async reset, active low
    input wire i_start, // one-cycle start pulse
    input wire signed [16:0] i_val, // decoded set value
    input wire signed [16:0] i_lo, // scale lower limit
    input wire signed [16:0] i_hi, // scale upper limit
    output reg o_busy, // conversion running
    output reg o_done, // one-cycle result pulse
    output reg [15:0] o_code // converter code
);
    wire signed [17:0] num = i_val - i_lo;
    wire signed [17:0] dnm = i_hi - i_lo;
    reg [33:0] dvd;
    reg [17:0] den;
    reg [18:0] rem;
    reg [15:0] quo;
    reg [5:0] cnt;
    wire [18:0] trial = {rem[17:0], dvd[33]};
    wire fits = trial >= {1'b0, den};
    wire [15:0] next_quo = {quo[14:0], fits};
    wire [33:0] prod = num[16:0] * DAC_FS;

    // lower limit maps to code 0, upper limit to full scale, linear between
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_code <= 16'h0000;
            dvd <= 34'h0_0000_0000;
            den <= 18'h0_0000;
            rem <= 19'h0_0000;
            quo <= 16'h0000;
            cnt <= 6'h00;
        end else begin
            o_done <= 1'b0;
            if (!o_busy && i_start) begin
                // bad span or out-of-span values clamp instead of dividing
                if (dnm <= 18'sh0_0000 || num <= 18'sh0_0000) begin
                    o_code <= 16'h0000;
                    o_done <= 1'b1;
                end else if (num >= dnm) begin
                    o_code <= DAC_FS;
                    o_done <= 1'b1;
                end else begin
                    dvd <= prod;
                    den <= dnm;
                    rem <= 19'h0_0000;
                    quo <= 16'h0000;
                    cnt <= `AOL_DIV_STEPS;
                    o_busy <= 1'b1;
                end
            end else if (o_busy) begin
                rem <= fits ? trial - {1'b0, den} : trial;
                quo <= next_quo;
                dvd <= {dvd[32:0], 1'b0};
                cnt <= cnt - 6'h01;
                if (cnt == 6'h01) begin
                    o_code <= next_quo;
                    o_done <= 1'b1;
                    o_busy <= 1'b0;
                end
            end
        end
    end
endmodule // aol_scale

// ===== aol_ctrl.v
// Functional notes
// - lower-limit check, off by default, raises error when value drops below limit
// - comm fault: enabled drives user fault value, else holds last output
// - comm idle: enabled drives user idle value, else holds last output
// - fault/idle options act only when retain source is software
// - non-scaled user values are plain decimal, volts or milliamps times 100
// - scaled set values are 16-bit sign-magnitude whatever the range
// - scaled: lower limit maps to range low end, upper to high end
// - four data formats, offset binary by default
// - upper-limit check raises error when value exceeds upper limit
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "aol_map.vh"
module aol_ctrl #(
    parameter [15:0] DAC_FS = 16'hFFFF
) (
    input wire i_mclk, // system clock, 100 MHz
    input wire i_rst_n, // async reset, active low
    input wire i_psel, // apb select
    input wire i_penable, // apb access phase
    input wire i_pwrite, // apb direction
    input wire [7:0] i_paddr, // apb byte address
    input wire [31:0] i_pwdata, // apb write data
    output reg [31:0] o_prdata, // apb read data
    output reg o_pready, // apb ready
    output reg o_pslverr, // apb error, unmapped address
    input wire i_comm_fault, // fieldbus communication error, async level
    input wire i_comm_idle, // fieldbus idle, async level
    input wire i_smp_valid, // converter input sample strobe
    input wire [15:0] i_smp_data, // converter input sample, in data format
    output reg [15:0] o_dac_data, // code to the converter
    output reg o_dac_valid, // one-cycle strobe with new code
    output reg o_irq // level interrupt
);
    reg [`AOL_CTRL_W-1:0] ctrl;
    reg [15:0] lo_lim;
    reg [15:0] hi_lim;
    reg [15:0] flt_val;
    reg [15:0] idl_val;
    reg [15:0] out_data;
    reg [`AOL_NEV-1:0] int_stat;
    reg [`AOL_NEV-1:0] int_mask;
    reg flt_s1;
    reg flt_s2;
    reg idl_s1;
    reg idl_s2;
    reg flt_d;
    reg idl_d;
    reg lo_in;
    reg hi_in;
    reg lo_out;
    reg hi_out;
    reg lo_d;
    reg hi_d;
    reg signed [16:0] drv_val;
    reg cfg_dirty;

    wire [1:0] fmt = ctrl[`AOL_C_FMT_MSB:`AOL_C_FMT_LSB];
    wire scaled = fmt == `AOL_FMT_SCAL;
    wire ret_sw = ctrl[`AOL_C_RET_SW];

    // sign-magnitude: msb is the sign, so 16'h8000 is minus zero
    function signed [16:0] smag;
        input [15:0] v;
        begin
            smag = v[15] ? -$signed({2'b00, v[14:0]}) : $signed({2'b00, v[14:0]});
        end
    endfunction

    function signed [16:0] dec_fmt;
        input [15:0] v;
        input [1:0] f;
        begin
            case (f)
                // offset binary puts zero at the midpoint code
                `AOL_FMT_OFFS: dec_fmt = $signed({1'b0, v}) - $signed(`AOL_OB_MID);
                `AOL_FMT_SMAG: dec_fmt = smag(v);
                `AOL_FMT_TWOS: dec_fmt = $signed({v[15], v});
                default: dec_fmt = smag(v);
            endcase
        end
    endfunction

    // user limits and values: sign-magnitude when scaled, else decimal x100
    function signed [16:0] dec_user;
        input [15:0] v;
        input s;
        begin
            dec_user = s ? smag(v) : $signed({v[15], v});
        end
    endfunction

    // limits decode like user values: sign-magnitude in scaled mode, else decimal
    wire signed [16:0] lo_s = dec_user(lo_lim, scaled);
    wire signed [16:0] hi_s = dec_user(hi_lim, scaled);
    // synchronised copies of the comm pins
    wire comm_flt = flt_s2;
    wire comm_idl = idl_s2;

    // fault outranks idle; without software retain the options are ignored
    wire use_flt = comm_flt & ret_sw & ctrl[`AOL_C_FLT_EN];
    wire use_idl = ~comm_flt & comm_idl & ret_sw & ctrl[`AOL_C_IDL_EN];
    wire hold = (comm_flt | comm_idl) & ~use_flt & ~use_idl;
    wire signed [16:0] cur_val = use_flt ? dec_user(flt_val, scaled) :
                                 use_idl ? dec_user(idl_val, scaled) :
                                 dec_fmt(out_data, fmt);
    wire changed = (cur_val != drv_val) | cfg_dirty;
    wire sc_busy;
    wire sc_done;
    wire [15:0] sc_code;
    // a change during a division waits; the running result lands first, then a restart
    wire sc_start = scaled & ~hold & ~sc_busy & changed;

    aol_scale #(
        .DAC_FS(DAC_FS)
    ) u_scale (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_start(sc_start),
        .i_val(cur_val),
        .i_lo(lo_s),
        .i_hi(hi_s),
        .o_busy(sc_busy),
        .o_done(sc_done),
        .o_code(sc_code)
    );

    wire signed [16:0] smp_val = dec_fmt(i_smp_data, fmt);
    // input and output side share one flag, so status cannot tell which one tripped
    wire lo_err = ctrl[`AOL_C_LO_EN] & (lo_in | lo_out);
    wire hi_err = ctrl[`AOL_C_HI_EN] & (hi_in | hi_out);
    // rising edges only: a violation that persists interrupts once, not every sample
    wire [`AOL_NEV-1:0] ev = {comm_idl & ~idl_d, comm_flt & ~flt_d,
                              hi_err & ~hi_d, lo_err & ~lo_d};

    // acc is the first access cycle; the answer follows one edge later, and any write lands on the edge after that
    wire acc = i_psel & i_penable & ~o_pready;
    wire wr_take = o_pready & i_psel & i_penable & i_pwrite;
    wire [`AOL_NEV-1:0] w1c = (wr_take && i_paddr == `AOL_A_INT_STAT) ?
                              i_pwdata[`AOL_NEV-1:0] : {`AOL_NEV{1'b0}};
    wire [`AOL_NEV-1:0] next_int_stat = (int_stat & ~w1c) | ev;
    // unmapped offsets answer with an error and read as zero
    reg hit;
    reg [31:0] rd;
    always @* begin
        hit = 1'b1;
        rd = 32'h0000_0000;
        case (i_paddr)
            `AOL_A_CTRL: rd[`AOL_CTRL_W-1:0] = ctrl;
            `AOL_A_LO_LIM: rd[15:0] = lo_lim;
            `AOL_A_HI_LIM: rd[15:0] = hi_lim;
            `AOL_A_FLT_VAL: rd[15:0] = flt_val;
            `AOL_A_IDL_VAL: rd[15:0] = idl_val;
            `AOL_A_OUT_DATA: rd[15:0] = out_data;
            `AOL_A_STATUS: rd[5:0] = {sc_busy, hold, comm_idl, comm_flt, hi_err, lo_err};
            `AOL_A_DAC_RB: rd[15:0] = o_dac_data;
            `AOL_A_INT_STAT: rd[`AOL_NEV-1:0] = int_stat;
            `AOL_A_INT_MASK: rd[`AOL_NEV-1:0] = int_mask;
            default: hit = 1'b0;
        endcase
    end

    // one wait state: pready is registered, writes land on the edge that ends the pready cycle
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= acc;
            o_pslverr <= acc & ~hit;
            if (acc && !i_pwrite) begin
                o_prdata <= rd;
            end
        end
    end

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl <= `AOL_RST_CTRL;
            lo_lim <= `AOL_RST_LO;
            hi_lim <= `AOL_RST_HI;
            flt_val <= `AOL_RST_VAL;
            idl_val <= `AOL_RST_VAL;
            out_data <= `AOL_RST_VAL;
            int_mask <= {`AOL_NEV{1'b0}};
        end else begin
            // status and readback offsets are read only; writes to them are dropped
            if (wr_take) begin
                case (i_paddr)
                    `AOL_A_CTRL: ctrl <= i_pwdata[`AOL_CTRL_W-1:0];
                    `AOL_A_LO_LIM: lo_lim <= i_pwdata[15:0];
                    `AOL_A_HI_LIM: hi_lim <= i_pwdata[15:0];
                    `AOL_A_FLT_VAL: flt_val <= i_pwdata[15:0];
                    `AOL_A_IDL_VAL: idl_val <= i_pwdata[15:0];
                    `AOL_A_OUT_DATA: out_data <= i_pwdata[15:0];
                    `AOL_A_INT_MASK: int_mask <= i_pwdata[`AOL_NEV-1:0];
                    default: ;
                endcase
            end
        end
    end

    // a format or limit write forces one re-drive so the output check sees new limits
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_dirty <= 1'b0;
        end else if (wr_take && (i_paddr == `AOL_A_CTRL || i_paddr == `AOL_A_LO_LIM ||
                                 i_paddr == `AOL_A_HI_LIM)) begin
            cfg_dirty <= 1'b1;
        end else if (sc_start || (!scaled && !hold)) begin
            // the write outranks the clear so a change landing with a start is not lost
            cfg_dirty <= 1'b0;
        end
    end

    // sticky events, write one to clear; a new event wins over the clear
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            int_stat <= {`AOL_NEV{1'b0}};
            o_irq <= 1'b0;
        end else begin
            int_stat <= next_int_stat;
            // irq follows the next status so a clear drops it without a stale cycle
            o_irq <= |(next_int_stat & int_mask);
        end
    end

    // the comm pins are asynchronous: only the second flop feeds any logic
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flt_s1 <= 1'b0;
            flt_s2 <= 1'b0;
            idl_s1 <= 1'b0;
            idl_s2 <= 1'b0;
        end else begin
            flt_s1 <= i_comm_fault;
            flt_s2 <= flt_s1;
            idl_s1 <= i_comm_idle;
            idl_s2 <= idl_s1;
        end
    end

    // previous levels for the rising-edge events; all start low like the idle pins
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flt_d <= 1'b0;
            idl_d <= 1'b0;
            lo_d <= 1'b0;
            hi_d <= 1'b0;
        end else begin
            flt_d <= flt_s2;
            idl_d <= idl_s2;
            lo_d <= lo_err;
            hi_d <= hi_err;
        end
    end

    // output path: while hold is set no new code is started; only a division already in flight still lands
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dac_data <= 16'h0000;
            o_dac_valid <= 1'b0;
            drv_val <= 17'h0_0000;
        end else begin
            o_dac_valid <= 1'b0;
            // scaled: drv_val is the value that the running division started from
            if (scaled) begin
                if (sc_start) begin
                    drv_val <= cur_val;
                end
                if (sc_done) begin
                    o_dac_data <= sc_code;
                    o_dac_valid <= 1'b1;
                end
            end else if (!hold && changed) begin
                drv_val <= cur_val;
                o_dac_data <= cur_val[15:0];
                o_dac_valid <= 1'b1;
            end
        end
    end

    // input flags hold their verdict until the next sample re-evaluates them, output flags until the next driven code
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lo_in <= 1'b0;
            hi_in <= 1'b0;
            lo_out <= 1'b0;
            hi_out <= 1'b0;
        end else begin
            if (i_smp_valid) begin
                lo_in <= smp_val < lo_s;
                hi_in <= smp_val > hi_s;
            end
            // a bad output is caught when it is driven, not only when sampled back
            if (o_dac_valid) begin
                lo_out <= drv_val < lo_s;
                hi_out <= drv_val > hi_s;
            end
        end
    end
endmodule // aol_ctrl

// ===== aol_ctrl_monitor.sv
`timescale 1ns/100ps
`include "aol_map.vh"
module aol_ctrl_monitor (
    input wire i_mclk, // clock
    input wire i_rst_n, // reset, active low
    input wire i_psel, // apb select
    input wire i_penable, // apb access
    input wire i_pwrite, // apb direction
    input wire [7:0] i_paddr, // apb address
    input wire [31:0] i_pwdata, // apb write data
    input wire o_pready, // apb ready
    input wire o_pslverr, // apb error
    input wire i_comm_fault, // comm error
    input wire i_comm_idle, // comm idle
    input wire [15:0] o_dac_data, // converter code
    input wire o_dac_valid // converter strobe
);
    reg [6:0] ctl;
    reg [15:0] fv;
    reg [15:0] iv;
    reg [5:0] fc;
    reg [5:0] fl;
    reg [5:0] ic;
    wire wr_done = i_psel && i_penable && i_pwrite && o_pready;
    wire flt_on = ctl[`AOL_C_FLT_EN] && ctl[`AOL_C_RET_SW];
    wire idl_on = ctl[`AOL_C_IDL_EN] && ctl[`AOL_C_RET_SW];
    wire raw = ctl[`AOL_C_FMT_MSB:`AOL_C_FMT_LSB] != `AOL_FMT_SCAL;
    // 40 cycles covers the synchroniser and a division already in flight
    wire flt_set = fc >= 6'h28;
    wire idl_set = ic >= 6'h28 && fl >= 6'h28;
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctl <= 7'h00;
            fv <= 16'h0000;
            iv <= 16'h0000;
            fc <= 6'h00;
            fl <= 6'h00;
            ic <= 6'h00;
        end else begin
            if (wr_done && i_paddr == `AOL_A_CTRL) ctl <= i_pwdata[6:0];
            if (wr_done && i_paddr == `AOL_A_FLT_VAL) fv <= i_pwdata[15:0];
            if (wr_done && i_paddr == `AOL_A_IDL_VAL) iv <= i_pwdata[15:0];
            fc <= i_comm_fault ? fc + {5'h00, fc != 6'h3F} : 6'h00;
            fl <= i_comm_fault ? 6'h00 : fl + {5'h00, fl != 6'h3F};
            ic <= i_comm_idle ? ic + {5'h00, ic != 6'h3F} : 6'h00;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    a_ready_wait: assert property ($rose(i_penable) && i_psel |-> !o_pready ##1 o_pready)
        else $error("ready not after one wait state");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (o_pready && i_paddr > `AOL_A_INT_MASK |-> o_pslverr)
        else $error("unmapped address not refused");
    a_err_mapped: assert property (o_pready && i_paddr <= `AOL_A_INT_MASK
        && i_paddr[1:0] == 2'h0 |-> !o_pslverr) else $error("mapped address refused");
    a_code_strobed: assert property ($changed(o_dac_data) |-> o_dac_valid)
        else $error("code changed without strobe");
    a_fault_hold: assert property (flt_set && !flt_on |-> !o_dac_valid)
        else $error("output moved during held fault");
    a_idle_hold: assert property (idl_set && !idl_on |-> !o_dac_valid)
        else $error("output moved during held idle");
    a_fault_value: assert property (flt_set && flt_on && raw |-> o_dac_data == fv)
        else $error("fault value not driven");
    a_idle_value: assert property (idl_set && idl_on && raw |-> o_dac_data == iv)
        else $error("idle value not driven");
    c_refused: cover property (o_pslverr);
    c_fault_drive: cover property (flt_set && flt_on);
    c_scaled_update: cover property (o_dac_valid && !raw);
endmodule // aol_ctrl_monitor
bind aol_ctrl aol_ctrl_monitor aol_ctrl_monitor_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_comm_fault(i_comm_fault), .i_comm_idle(i_comm_idle), .o_dac_data(o_dac_data),
    .o_dac_valid(o_dac_valid));

// ===== aol_cnv_model.sv
`timescale 1ns/100ps
module aol_cnv_model (
    input wire i_mclk, // clock
    input wire [15:0] i_dac_data, // code from the controller
    input wire i_dac_valid, // new code strobe
    output reg o_smp_valid, // sample strobe
    output wire [15:0] o_smp_data // sample in data format
);
    reg [15:0] smp_d = 16'h0000;
    reg [15:0] last_code = 16'h0000;
    integer n_upd = 0;
    // between strobes the line shows the inverse so a stale value never looks valid
    assign o_smp_data = o_smp_valid ? smp_d : ~smp_d;
    initial o_smp_valid = 1'b0;
    always @(posedge i_mclk) begin
        if (i_dac_valid === 1'b1) begin
            last_code <= i_dac_data;
            n_upd <= n_upd + 1;
        end
    end
    task sample(input [15:0] d);
        begin
            @(posedge i_mclk);
            smp_d <= d;
            o_smp_valid <= 1'b1;
            @(posedge i_mclk);
            o_smp_valid <= 1'b0;
        end
    endtask
endmodule // aol_cnv_model

// ===== testbench.sv
`timescale 1ns/100ps
`include "aol_map.vh"
`define CHK(a, x) begin compares = compares + 1; if ((a) !== (x)) begin \
    n_mismatch = n_mismatch + 1; $display("[ERR] %0t got %h exp %h", $time, a, x); end end
module testbench;
    reg mclk, rst_n, psel, penable, pwrite, fault, idle, err;
    reg [7:0] paddr;
    reg [31:0] pwdata;
    reg [31:0] q;
    reg [47:0] tbl [0:6];
    wire [31:0] prdata;
    wire pready, pslverr, dac_valid, irq, smp_valid;
    wire [15:0] dac_data, smp_data;
    integer n_mismatch, compares, k, j, nu;
    aol_ctrl #(.DAC_FS(16'h03E8)) aol_ctrl_i (.i_mclk(mclk), .i_rst_n(rst_n),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_comm_fault(fault), .i_comm_idle(idle), .i_smp_valid(smp_valid),
        .i_smp_data(smp_data), .o_dac_data(dac_data), .o_dac_valid(dac_valid), .o_irq(irq));
    aol_cnv_model aol_cnv_model_i (.i_mclk(mclk), .i_dac_data(dac_data),
        .i_dac_valid(dac_valid), .o_smp_valid(smp_valid), .o_smp_data(smp_data));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task results;
        begin
            $display("compares %0d mismatches %0d", compares, n_mismatch);
            if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    task stuck;
        begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t wait ran out", $time);
            results;
        end
    endtask
    task apb(input w, input [7:0] a, input [15:0] d);
        begin
            @(posedge mclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= {16'h0000, d};
            @(posedge mclk);
            penable <= 1'b1;
            for (j = 0; j < 20 && pready !== 1'b1; j = j + 1) @(posedge mclk);
            if (j == 20) stuck;
            q = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wait_code(input [15:0] x);
        begin
            for (j = 0; j < 100 && aol_cnv_model_i.last_code !== x; j = j + 1) @(posedge mclk);
            if (j == 100) stuck;
        end
    endtask
    initial begin
        {rst_n, psel, penable, pwrite, fault, idle, err} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        n_mismatch = 0;
        compares = 0;
        tbl[0] = 48'h0000_841A_041A;
        tbl[1] = 48'h0010_8005_FFFB;
        tbl[2] = 48'h0020_012C_012C;
        tbl[3] = 48'h0030_01F4_01F4;
        tbl[4] = 48'h0030_8064_0000;
        tbl[5] = 48'h0030_0400_03E8;
        tbl[6] = 48'h0000_8000_0000;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        for (k = 0; k < 7; k = k + 1) begin
            apb(1'b1, `AOL_A_CTRL, tbl[k][47:32]);
            apb(1'b1, `AOL_A_OUT_DATA, tbl[k][31:16]);
            wait_code(tbl[k][15:0]);
            `CHK(aol_cnv_model_i.last_code, tbl[k][15:0])
        end
        $display("format table done");
        apb(1'b1, `AOL_A_CTRL, 16'h0030);
        apb(1'b1, `AOL_A_LO_LIM, 16'h03E8);
        apb(1'b1, `AOL_A_HI_LIM, 16'h1388);
        apb(1'b1, `AOL_A_OUT_DATA, 16'h0FA0);
        wait_code(16'h02EE);
        `CHK(aol_cnv_model_i.last_code, 16'h02EE)
        $display("scaled span done");
        rst_n <= 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b0, `AOL_A_CTRL, 16'h0000);
        `CHK(q, 32'h0000_0000)
        apb(1'b0, `AOL_A_HI_LIM, 16'h0000);
        `CHK(q, 32'h0000_03E8)
        apb(1'b0, `AOL_A_LO_LIM, 16'h0000);
        `CHK(q, 32'h0000_0000)
        apb(1'b0, 8'h30, 16'h0000);
        `CHK({err, q}, 33'h1_0000_0000)
        $display("reset and refusal done");
        apb(1'b1, `AOL_A_OUT_DATA, 16'h81F4);
        wait_code(16'h01F4);
        apb(1'b1, `AOL_A_LO_LIM, 16'h012C);
        apb(1'b1, `AOL_A_CTRL, 16'h0003);
        aol_cnv_model_i.sample(16'h8064);
        apb(1'b0, `AOL_A_STATUS, 16'h0000);
        `CHK(q[1:0], 2'h1)
        aol_cnv_model_i.sample(16'h8190);
        apb(1'b0, `AOL_A_STATUS, 16'h0000);
        `CHK(q[1:0], 2'h0)
        aol_cnv_model_i.sample(16'h844C);
        apb(1'b0, `AOL_A_STATUS, 16'h0000);
        `CHK(q[1:0], 2'h2)
        apb(1'b0, `AOL_A_INT_STAT, 16'h0000);
        `CHK(q[3:0], 4'h3)
        `CHK(irq, 1'b0)
        apb(1'b1, `AOL_A_INT_MASK, 16'h0001);
        repeat (2) @(posedge mclk);
        `CHK(irq, 1'b1)
        apb(1'b1, `AOL_A_INT_STAT, 16'h0003);
        repeat (2) @(posedge mclk);
        `CHK(irq, 1'b0)
        $display("limits and interrupt done");
        apb(1'b1, `AOL_A_FLT_VAL, 16'h0190);
        apb(1'b1, `AOL_A_IDL_VAL, 16'h00C8);
        apb(1'b1, `AOL_A_CTRL, 16'h004C);
        idle <= 1'b1;
        wait_code(16'h00C8);
        `CHK(aol_cnv_model_i.last_code, 16'h00C8)
        fault <= 1'b1;
        wait_code(16'h0190);
        `CHK(aol_cnv_model_i.last_code, 16'h0190)
        repeat (45) @(posedge mclk);
        fault <= 1'b0;
        wait_code(16'h00C8);
        `CHK(aol_cnv_model_i.last_code, 16'h00C8)
        repeat (45) @(posedge mclk);
        idle <= 1'b0;
        wait_code(16'h01F4);
        apb(1'b1, `AOL_A_CTRL, 16'h000C);
        fault <= 1'b1;
        repeat (45) @(posedge mclk);
        nu = aol_cnv_model_i.n_upd;
        apb(1'b1, `AOL_A_OUT_DATA, 16'h8258);
        repeat (20) @(posedge mclk);
        `CHK(aol_cnv_model_i.n_upd, nu)
        fault <= 1'b0;
        wait_code(16'h0258);
        apb(1'b1, `AOL_A_CTRL, 16'h0040);
        idle <= 1'b1;
        repeat (45) @(posedge mclk);
        apb(1'b1, `AOL_A_OUT_DATA, 16'h8064);
        repeat (20) @(posedge mclk);
        `CHK(aol_cnv_model_i.last_code, 16'h0258)
        idle <= 1'b0;
        wait_code(16'h0064);
        `CHK(aol_cnv_model_i.last_code, 16'h0064)
        apb(1'b0, `AOL_A_DAC_RB, 16'h0000);
        `CHK(q, 32'h0000_0064)
        $display("fault and idle done");
        results;
    end
endmodule // testbench
